// ==== verilog/wdog_pkg.sv ====
`default_nettype none

package wdog_pkg;

  // counter structure
  localparam int unsigned PRESCALE_W = 12;
  localparam int unsigned COUNT_W = 6;
  localparam int unsigned WAKE_W = 13;
  localparam int unsigned PULSE_W = 6;

  // register indices; byte address is four times the index
  localparam logic [15:0] SERVICE_PORT_IDX = 16'hffff;
  localparam logic [15:0] OPTION_ONE_IDX = 16'h001f;
  localparam logic [15:0] RESET_CAUSE_IDX = 16'h0001;
  localparam logic [15:0] WDOG_STATUS_IDX = 16'h0002;

  // system_option_register_one fields
  localparam int unsigned OPT_RATE_BIT = 7;
  localparam int unsigned OPT_SHORT_WAKE_BIT = 2;
  localparam int unsigned OPT_STOP_EN_BIT = 1;
  localparam int unsigned OPT_DISABLE_BIT = 0;
  localparam logic [7:0] OPTION_ONE_RESET = 8'h00;

  // reset_cause_register fields
  localparam int unsigned CAUSE_WDOG_BIT = 0;
  localparam int unsigned CAUSE_ILLEGAL_BIT = 1;
  localparam logic [1:0] CAUSE_RESET = 2'h0;

  // timing in osc_clock cycles
  localparam int unsigned TIMEOUT_FAST_CYCLES = 8176;
  localparam int unsigned TIMEOUT_SLOW_CYCLES = 262128;
  localparam int unsigned RST_PULSE_CYCLES = 32;
  localparam int unsigned POR_SETTLE_CYCLES = 4096;
  localparam int unsigned SHORT_WAKE_CYCLES = 32;
  localparam int unsigned LONG_WAKE_CYCLES = 4096;

  // prescaler stage whose carry advances the counter, per rate
  localparam int unsigned FAST_TAP = 7;
  localparam int unsigned SLOW_TAP = 12;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_STOP = 3'b010,
    MODE_RECOVER = 3'b100
  } wdog_mode_type;

  typedef struct packed {
    logic [2:0] sync_irq;
    logic [2:0] sync_rst;
    logic irq_tst;
    logic rst_tst;
    logic [PRESCALE_W-1:0] presc;
    logic [COUNT_W-1:0] cnt;
    logic [PRESCALE_W-1:0] por_cnt;
    logic por_done;
    wdog_mode_type mode;
    logic [WAKE_W-1:0] wake_cnt;
    logic wake_long;
    logic pulse;
    logic [PULSE_W-1:0] pulse_cnt;
    logic [7:0] opt;
    logic opt_written;
    logic [1:0] cause;
    logic mon_irq;
    logic mon_blank;
    logic cpu_clk_en;
    logic wdog_active;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } wdog_state_type;

  localparam wdog_state_type STATE_RESET = '{
    mode: MODE_RUN,
    cpu_clk_en: 1'b1,
    opt: OPTION_ONE_RESET,
    cause: CAUSE_RESET,
    default: '0
  };

endpackage : wdog_pkg

`default_nettype wire

// ==== verilog/wdog_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - 6-bit counter behind 12-bit prescaler
// - timeout 8176 or 262128 by rate
// - timeout drives reset pin 32 cycles, flags
// - service write clears counter, prescaler 12-5
// - service read returns reset vector low
// - disable bit blocks watchdog resets
// - prescaler cleared 4096 cycles after power-up
// - internal reset clears both counters
// - no interrupt, only reset
// - monitor via irq test: disabled while voltage
// - monitor via blank vectors: off until POR
// - break with reset-pin test voltage disables
// - keeps counting in wait mode
// - stop gates clock, clears prescaler
// - stop disabled means illegal-opcode reset
// - wake after 32 or 4096 cycles
// - reset out of stop: long recovery
// - option register written once per reset
// - every reset clears option bits
module wdog_top
  import wdog_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [17:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [7:0] I_RESET_VEC_LO,
  input wire logic I_STOP_EXEC,
  input wire logic I_WAKE_REQ,
  input wire logic I_INT_RST,
  input wire logic I_MON_ENTRY,
  input wire logic I_MON_BY_TST,
  input wire logic I_BREAK_STATE,
  input wire logic I_IRQ_TST,
  input wire logic I_RST_TST,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_RST_PIN_OUT,
  output logic O_RST_PIN_OE_N,
  output logic O_INT_RESET,
  output logic O_CPU_CLK_EN,
  output logic O_WDOG_ACTIVE
);

  localparam logic [COUNT_W-1:0] CNT_MAX = '1;
  localparam logic [PRESCALE_W-1:0] FAST_MASK = PRESCALE_W'((1 << FAST_TAP) - 1);
  localparam logic [PRESCALE_W-1:0] SLOW_MASK = PRESCALE_W'((1 << SLOW_TAP) - 1);
  // the overflow lands at the prescaler value that makes the total exact
  localparam logic [PRESCALE_W-1:0] FAST_END =
    PRESCALE_W'(TIMEOUT_FAST_CYCLES - ((1 << COUNT_W) - 1) * (1 << FAST_TAP) - 1);
  localparam logic [PRESCALE_W-1:0] SLOW_END =
    PRESCALE_W'(TIMEOUT_SLOW_CYCLES - ((1 << COUNT_W) - 1) * (1 << SLOW_TAP) - 1);
  localparam logic [PRESCALE_W-1:0] POR_END = PRESCALE_W'(POR_SETTLE_CYCLES - 1);
  localparam logic [PULSE_W-1:0] PULSE_END = PULSE_W'(RST_PULSE_CYCLES - 1);
  localparam logic [WAKE_W-1:0] SHORT_WAKE_END = WAKE_W'(SHORT_WAKE_CYCLES - 1);
  localparam logic [WAKE_W-1:0] LONG_WAKE_END = WAKE_W'(LONG_WAKE_CYCLES - 1);
  localparam logic [PRESCALE_W-1:0] SERVICE_KEEP = PRESCALE_W'(12'h00f);

  wdog_state_type q;
  wdog_state_type d;

  logic setup_phase;
  logic access_done;
  logic [15:0] reg_idx;
  logic hit_service;
  logic hit_option;
  logic hit_cause;
  logic hit_status;
  logic wdog_off;
  logic counting;
  logic fast_rate;
  logic tick;
  logic overflow;
  logic service;
  logic illegal_stop;
  logic start_reset;
  logic [PRESCALE_W-1:0] presc_mask;
  logic [PRESCALE_W-1:0] presc_end;
  logic [31:0] read_word;

  always_comb begin
    d = q;

    // pins from outside: three flops, change taken when the last two agree
    d.sync_irq = {q.sync_irq[1:0], I_IRQ_TST};
    d.sync_rst = {q.sync_rst[1:0], I_RST_TST};
    if (q.sync_irq[2] == q.sync_irq[1]) begin
      d.irq_tst = q.sync_irq[2];
    end
    if (q.sync_rst[2] == q.sync_rst[1]) begin
      d.rst_tst = q.sync_rst[2];
    end

    // register decode, held stable by the master through the access phase
    setup_phase = I_PSEL & ~I_PENABLE;
    access_done = I_PSEL & I_PENABLE & q.pready;
    reg_idx = I_PADDR[17:2];
    hit_service = (reg_idx == SERVICE_PORT_IDX);
    hit_option = (reg_idx == OPTION_ONE_IDX);
    hit_cause = (reg_idx == RESET_CAUSE_IDX);
    hit_status = (reg_idx == WDOG_STATUS_IDX);

    wdog_off = q.opt[OPT_DISABLE_BIT] | q.mon_blank
             | (q.mon_irq & (q.irq_tst | q.rst_tst))
             | (I_BREAK_STATE & q.rst_tst);

    counting = (q.mode == MODE_RUN) & q.por_done & ~q.pulse;

    fast_rate = q.opt[OPT_RATE_BIT];
    presc_mask = fast_rate ? FAST_MASK : SLOW_MASK;
    presc_end = fast_rate ? FAST_END : SLOW_END;
    tick = counting & ((q.presc & presc_mask) == presc_mask);
    overflow = counting & ~wdog_off & (q.cnt == CNT_MAX)
             & ((q.presc & presc_mask) == presc_end);

    service = access_done & I_PWRITE & hit_service;
    illegal_stop = I_STOP_EXEC & (q.mode == MODE_RUN) & ~q.opt[OPT_STOP_EN_BIT];
    start_reset = ~q.pulse & (overflow | illegal_stop | I_INT_RST);

    if (counting) begin
      d.presc = q.presc + PRESCALE_W'(1);
      if (tick) begin
        d.cnt = q.cnt + COUNT_W'(1);
      end
    end

    if (!q.por_done) begin
      d.por_cnt = q.por_cnt + PRESCALE_W'(1);
      if (q.por_cnt == POR_END) begin
        d.por_done = 1'b1;
        d.presc = '0;
      end
    end

    // service clears counter and upper stages
    if (service) begin
      d.cnt = '0;
      d.presc = q.presc & SERVICE_KEEP;
    end

    // read data is latched in the setup cycle, answered one cycle later
    read_word = '0;
    if (hit_service) begin
      read_word[7:0] = I_RESET_VEC_LO;
    end else if (hit_option) begin
      read_word[7:0] = q.opt;
    end else if (hit_cause) begin
      read_word[1:0] = q.cause;
    end else if (hit_status) begin
      read_word = {16'h0000, q.mode, q.cpu_clk_en, q.wdog_active, q.pulse,
                   q.cnt[5:0], 4'h0};
    end

    d.pready = 1'b0;
    if (setup_phase) begin
      d.pready = 1'b1;
      d.pslverr = ~(hit_service | hit_option | hit_cause | hit_status);
      d.prdata = I_PWRITE ? 32'h0000_0000 : read_word;
    end

    if (access_done && I_PWRITE && hit_option && !q.opt_written) begin
      d.opt = I_PWDATA[7:0];
      d.opt_written = 1'b1;
    end

    // write-one clears the cause; a new cause in the same cycle wins below
    if (access_done && I_PWRITE && hit_cause) begin
      d.cause = q.cause & ~I_PWDATA[1:0];
    end

    // monitor entry decides which disable form applies
    if (I_MON_ENTRY) begin
      if (I_MON_BY_TST) begin
        d.mon_irq = 1'b1;
      end else begin
        d.mon_blank = 1'b1;
      end
    end

    case (q.mode)
      MODE_RUN: begin
        if (I_STOP_EXEC && q.opt[OPT_STOP_EN_BIT] && !start_reset) begin
          d.mode = MODE_STOP;
          d.presc = '0;
          d.cpu_clk_en = 1'b0;
        end
      end
      MODE_STOP: begin
        if (I_WAKE_REQ) begin
          d.mode = MODE_RECOVER;
          d.wake_cnt = '0;
          d.wake_long = ~q.opt[OPT_SHORT_WAKE_BIT];
        end
      end
      MODE_RECOVER: begin
        d.wake_cnt = q.wake_cnt + WAKE_W'(1);
        if (q.wake_cnt == (q.wake_long ? LONG_WAKE_END : SHORT_WAKE_END)) begin
          d.mode = MODE_RUN;
          d.cpu_clk_en = 1'b1;
        end
      end
      default: begin
        d.mode = MODE_RUN;
        d.cpu_clk_en = 1'b1;
      end
    endcase

    if (q.pulse) begin
      d.pulse_cnt = q.pulse_cnt + PULSE_W'(1);
      if (q.pulse_cnt == PULSE_END) begin
        d.pulse = 1'b0;
      end
    end

    if (start_reset) begin
      d.pulse = 1'b1;
      d.pulse_cnt = '0;
      if (overflow) begin
        d.cause[CAUSE_WDOG_BIT] = 1'b1;
      end
      if (illegal_stop) begin
        d.cause[CAUSE_ILLEGAL_BIT] = 1'b1;
      end
      d.presc = '0;
      d.cnt = '0;
      d.opt = OPTION_ONE_RESET;
      d.opt_written = 1'b0;
      // reset out of stop is long
      if (q.mode != MODE_RUN) begin
        d.mode = MODE_RECOVER;
        d.wake_cnt = '0;
        d.wake_long = 1'b1;
      end
    end

    d.wdog_active = ~wdog_off & q.por_done;
  end

  // power-on reset also restarts settle count
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign O_PRDATA = q.prdata;
  assign O_PREADY = q.pready;
  assign O_PSLVERR = q.pslverr;
  // pin is pulled low only while the pulse runs; the level is low then
  assign O_RST_PIN_OUT = ~q.pulse;
  assign O_RST_PIN_OE_N = ~q.pulse;
  assign O_INT_RESET = q.pulse;
  assign O_CPU_CLK_EN = q.cpu_clk_en;
  assign O_WDOG_ACTIVE = q.wdog_active;

endmodule : wdog_top

`default_nettype wire

// ==== dv/wdog_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdog_props (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_STOP_EXEC,
  input wire logic I_WAKE_REQ,
  input wire logic I_INT_RST,
  input wire logic I_BREAK_STATE,
  input wire logic I_RST_TST,
  input wire logic O_RST_PIN_OUT,
  input wire logic O_RST_PIN_OE_N,
  input wire logic O_INT_RESET,
  input wire logic O_CPU_CLK_EN,
  input wire logic O_WDOG_ACTIVE
);
  logic [5:0] hi_q;
  logic [12:0] up_q;
  logic [12:0] wk_q;
  // pulse length, and cycles since power-on release (saturating)
  always_ff @(posedge I_REF_CLK) begin
    hi_q <= O_INT_RESET ? hi_q + 6'h01 : 6'h00;
    up_q <= I_SYS_RST ? 13'h0000 : up_q + {12'h000, ~&up_q};
    // cycles since a wake request while stopped; too long for a delay range
    if (I_SYS_RST || O_CPU_CLK_EN) begin
      wk_q <= 13'h0000;
    end else if (wk_q != 13'h0000) begin
      wk_q <= wk_q + {12'h000, ~&wk_q};
    end else if (I_WAKE_REQ && !O_INT_RESET) begin
      wk_q <= 13'h0001;
    end
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_stop;
    I_STOP_EXEC && O_CPU_CLK_EN && !O_INT_RESET;
  endsequence
  sequence s_wake;
    I_WAKE_REQ && !O_CPU_CLK_EN && !O_INT_RESET;
  endsequence
  property p_len;
    $fell(O_INT_RESET) |-> hi_q == 6'h20;
  endproperty
  property p_oe;
    O_RST_PIN_OE_N == !O_INT_RESET;
  endproperty
  property p_lvl;
    !O_RST_PIN_OE_N |-> !O_RST_PIN_OUT;
  endproperty
  property p_stop;
    s_stop |=> !O_CPU_CLK_EN || O_INT_RESET;
  endproperty
  property p_wake;
    s_wake |=> (!O_CPU_CLK_EN)[*8];
  endproperty
  property p_wake_max;
    wk_q != 13'h0000 |-> wk_q <= 13'h1004;
  endproperty
  property p_src;
    $rose(O_INT_RESET) |-> $past(O_WDOG_ACTIVE || I_INT_RST || I_STOP_EXEC);
  endproperty
  property p_settle;
    O_WDOG_ACTIVE |-> up_q >= 13'h1000;
  endproperty
  property p_brk;
    (I_BREAK_STATE && I_RST_TST)[*8] |-> !O_WDOG_ACTIVE;
  endproperty
  a_len: assert property (p_len) else $error("pulse length");
  a_oe: assert property (p_oe) else $error("pin enable");
  a_lvl: assert property (p_lvl) else $error("pin level");
  a_stop: assert property (p_stop) else $error("stop entry");
  a_wake: assert property (p_wake) else $error("wake delay");
  a_wake_max: assert property (p_wake_max) else $error("wake too late");
  a_src: assert property (p_src) else $error("reset source");
  a_settle: assert property (p_settle) else $error("early arm");
  a_brk: assert property (p_brk) else $error("break arm");
endmodule : wdog_props
bind wdog_top wdog_props u_props (.*);
`default_nettype wire

// ==== dv/wdog_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdog_top_tb
  import wdog_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pu = 4'h0;
  logic mtst = 1'b0;
  logic brk = 1'b0;
  logic itst = 1'b0;
  logic rtst = 1'b0;
  logic [31:0] prdata;
  logic pready, perr, pin, oen, ires, cken, act;
  logic [31:0] rv;
  logic re;
  logic [7:0] vec = 8'h5a;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t;
  int n;
  wdog_top DUT (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_RESET_VEC_LO(vec),
    .I_STOP_EXEC(pu[0]), .I_WAKE_REQ(pu[1]), .I_INT_RST(pu[2]), .I_MON_ENTRY(pu[3]),
    .I_MON_BY_TST(mtst), .I_BREAK_STATE(brk), .I_IRQ_TST(itst), .I_RST_TST(rtst),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr), .O_RST_PIN_OUT(pin),
    .O_RST_PIN_OE_N(oen), .O_INT_RESET(ires), .O_CPU_CLK_EN(cken), .O_WDOG_ACTIVE(act));
  always #12.5 clk = ~clk;
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // the whole sequence needs about 40000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      summarize;
    end
  end
  task automatic cy(input int k);
    repeat (k) @(posedge clk);
  endtask : cy
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one spare edge at the end keeps psel from being assigned twice at once
  task automatic apb(input logic [15:0] ix, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    re = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [15:0] ix, input logic [31:0] e, input string nm);
    apb(ix, 1'b0, 32'h0);
    chk(nm, e, rv);
  endtask : rd
  task automatic pl(input int k);
    pu <= 4'h1 << k;
    cy(1);
    pu <= 4'h0;
    cy(1);
  endtask : pl
  task automatic drain;
    while (ires === 1'b1) cy(1);
  endtask : drain
  task automatic wake_in(input int lo, input int hi, input string nm);
    t = cyc;
    while (cken !== 1'b1) cy(1);
    chk(nm, 32'h1, {31'h0, (cyc - t) inside {[lo:hi]}});
  endtask : wake_in
  initial begin
    cy(12);
    rst <= 1'b0;
    cy(1);
    chk("oe_n", 32'h1, {31'h0, oen});
    rd(OPTION_ONE_IDX, 32'h0, "option");
    rd(SERVICE_PORT_IDX, 32'h5a, "service read");
    chk("no slverr", 32'h0, {31'h0, re});
    vec <= 8'ha5;
    rd(SERVICE_PORT_IDX, 32'ha5, "service read 2");
    apb(16'h0003, 1'b0, 32'h0);
    chk("slverr", 32'h1, {31'h0, re});
    apb(OPTION_ONE_IDX, 1'b1, 32'h86);
    apb(OPTION_ONE_IDX, 1'b1, 32'h00);
    rd(OPTION_ONE_IDX, 32'h86, "option lock");
    cy(4100);
    chk("armed", 32'h1, {31'h0, act});
    repeat (2) begin
      apb(SERVICE_PORT_IDX, 1'b1, 32'h0);
      cy(5000);
    end
    rd(RESET_CAUSE_IDX, 32'h0, "serviced");
    apb(SERVICE_PORT_IDX, 1'b1, 32'h0);
    t = cyc;
    while (ires !== 1'b1) cy(1);
    chk("timeout", 32'h1, {31'h0, (cyc - t) inside {[8158:8180]}});
    chk("oe_n low", 32'h0, {31'h0, oen});
    chk("pin low", 32'h0, {31'h0, pin});
    n = 0;
    while (ires === 1'b1) begin
      n++;
      cy(1);
    end
    chk("pulse", 32'h20, n);
    rd(RESET_CAUSE_IDX, 32'h1, "cause wdog");
    rd(OPTION_ONE_IDX, 32'h0, "option cleared");
    apb(RESET_CAUSE_IDX, 1'b1, 32'h3);
    apb(OPTION_ONE_IDX, 1'b1, 32'h87);
    cy(9000);
    rd(RESET_CAUSE_IDX, 32'h0, "disabled");
    chk("disarmed", 32'h0, {31'h0, act});
    pl(0);
    chk("stopped", 32'h0, {31'h0, cken});
    cy(50);
    pl(1);
    wake_in(28, 34, "short wake");
    pl(2);
    drain;
    rd(OPTION_ONE_IDX, 32'h0, "option int reset");
    rd(WDOG_STATUS_IDX, 32'h3800, "counters cleared");
    pl(0);
    drain;
    rd(RESET_CAUSE_IDX, 32'h2, "cause illegal");
    apb(OPTION_ONE_IDX, 1'b1, 32'h02);
    pl(0);
    cy(20);
    pl(1);
    wake_in(4090, 4100, "long wake");
    pl(0);
    cy(20);
    pl(2);
    wake_in(4090, 4140, "reset wake");
    brk <= 1'b1;
    rtst <= 1'b1;
    cy(10);
    chk("break", 32'h0, {31'h0, act});
    brk <= 1'b0;
    rtst <= 1'b0;
    cy(10);
    chk("break end", 32'h1, {31'h0, act});
    mtst <= 1'b1;
    itst <= 1'b1;
    pl(3);
    cy(10);
    chk("monitor tst", 32'h0, {31'h0, act});
    itst <= 1'b0;
    cy(10);
    chk("tst removed", 32'h1, {31'h0, act});
    mtst <= 1'b0;
    pl(3);
    cy(10);
    chk("monitor blank", 32'h0, {31'h0, act});
    pl(2);
    drain;
    cy(10);
    chk("blank kept", 32'h0, {31'h0, act});
    summarize;
  end
endmodule : wdog_top_tb
`default_nettype wire
